// ### logic/dma_chan_ctrl.sv
`timescale 1ns/100ps
//==========================================================================
// Overview of operation
// RULE1: Channel enable clear register has one bit per channel, bits 15 to 0.
// RULE2: Reading enable clear returns live enable state, not last written value.
// RULE3: Writing one to an enable clear bit disables that channel; zeros ignored.
// RULE4: Enable clear writes never enable; only the enable set register enables.
// RULE5: Channel completion clears that channel's enable bit automatically; the code lets a same-cycle enable set write win.
// RULE6: After reset all channel enable bits are zero.
// RULE7: Alternate set read returns zero for primary, one for alternate structure.
// RULE8: Writing one to an alternate set bit selects alternate; zeros ignored.
// RULE9: Return to primary only through alternate clear, never the set register.
// RULE10: Engine sets and clears alternate bits itself during ping-pong and scatter-gather.
// RULE11: After reset every channel selects its primary structure.
// RULE12: Enable set writes of one enable channels; reads return enable status.
// RULE13: Upper bits read zero, ignore writes; concurrent disables just leave channel off.
module dma_chan_ctrl
(
  // Clock, reset, enable
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      clk_en_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [31:0]               wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Transfer engine side
  input  wire dma_chan_pkg::engine_evt_t engine_i,
  output dma_chan_pkg::chan_status_t     status_o
);

  import dma_chan_pkg::*;

  //========================================================================
  // Address decode
  //========================================================================
  reg_sel_t  sel;
  logic      req;
  logic      acc;
  logic      ack_r;
  logic      ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  chan_vec_t wr_bits;
  chan_vec_t en_q;
  chan_vec_t alt_q;
  chan_vec_t en_set;
  chan_vec_t en_clr;
  chan_vec_t alt_set;
  chan_vec_t alt_clr;
  chan_vec_t sw_en_set;
  chan_vec_t sw_en_clr;
  chan_vec_t sw_alt_set;
  chan_vec_t sw_alt_clr;

  always_comb
  begin
    case (wb_adr_i)
      ADDR_EN_SET:  sel = SEL_EN_SET;
      ADDR_EN_CLR:  sel = SEL_EN_CLR;   // [RULE1]
      ADDR_ALT_SET: sel = SEL_ALT_SET;
      ADDR_ALT_CLR: sel = SEL_ALT_CLR;
      default:      sel = SEL_NONE;
    endcase
  end

  // One access per request; ack_r blocks a second take in the ack cycle
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign acc = req & clk_en_i;

  // Only channel bits are writable; upper lanes are dropped
  assign wr_bits = wb_dat_i[CHAN_MSB:CHAN_LSB]
                 & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};   // [RULE13]

  //========================================================================
  // Write strobes
  //========================================================================
  always_comb
  begin
    sw_en_set  = '0;
    sw_en_clr  = '0;
    sw_alt_set = '0;
    sw_alt_clr = '0;
    if (acc && wb_we_i)
    begin
      case (sel)
        SEL_EN_SET:  sw_en_set  = wr_bits;   // [RULE12]
        SEL_EN_CLR:  sw_en_clr  = wr_bits;   // [RULE3] [RULE4]
        SEL_ALT_SET: sw_alt_set = wr_bits;   // [RULE8] [RULE9]
        SEL_ALT_CLR: sw_alt_clr = wr_bits;
        default:     sw_en_set  = '0;
      endcase
    end
  end

  // Software and completion clears simply OR together
  assign en_set  = sw_en_set;
  assign en_clr  = sw_en_clr | engine_i.done;             // [RULE5] [RULE13]
  assign alt_set = sw_alt_set | engine_i.alt_set;         // [RULE10]
  assign alt_clr = sw_alt_clr | engine_i.alt_clr;         // [RULE10]

  //========================================================================
  // Channel state
  //========================================================================
  // Reset to zero inside the cells
  // Reset does not wait for the clock enable, so a frozen block still clears
  chan_bit_cell #(
    .WIDTH    (NUM_CHAN)
  ) u_enable (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),                                   // [RULE6]
    .clk_en_i (clk_en_i),
    .set_i    (en_set),
    .clr_i    (en_clr),
    .q_o      (en_q)
  );

  chan_bit_cell #(
    .WIDTH    (NUM_CHAN)
  ) u_alt_sel (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),                                   // [RULE11]
    .clk_en_i (clk_en_i),
    .set_i    (alt_set),
    .clr_i    (alt_clr),
    .q_o      (alt_q)
  );

  assign status_o.enable  = en_q;
  assign status_o.alt_sel = alt_q;

  //========================================================================
  // Bus answer
  //========================================================================
  // Writes return zero so stale data never poses as a fresh read
  always_comb
  begin
    ack_nxt   = ack_r;
    rdata_nxt = rdata_r;
    if (clk_en_i)
    begin
      ack_nxt = req;
      if (req && !wb_we_i)
      begin
        case (sel)
          SEL_EN_SET:  rdata_nxt = {RSVD_READ, en_q};    // [RULE12]
          SEL_EN_CLR:  rdata_nxt = {RSVD_READ, en_q};    // [RULE2]
          SEL_ALT_SET: rdata_nxt = {RSVD_READ, alt_q};   // [RULE7]
          SEL_ALT_CLR: rdata_nxt = {RSVD_READ, alt_q};
          default:     rdata_nxt = RDATA_RST;
        endcase
      end
      else if (req)
      begin
        rdata_nxt = RDATA_RST;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ack_r   <= 1'b0;
      rdata_r <= RDATA_RST;
    end
    else
    begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  //========================================================================
  // Checks
  //========================================================================
  // Bus and engine share one clock, so one default domain serves all
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  logic wr_en_clr;
  logic wr_en_set;
  logic rd_en_clr;
  logic rd_alt_set;
  assign wr_en_clr  = acc & wb_we_i & (sel == SEL_EN_CLR);
  assign wr_en_set  = acc & wb_we_i & (sel == SEL_EN_SET);
  assign rd_en_clr  = acc & ~wb_we_i & (sel == SEL_EN_CLR);
  assign rd_alt_set = acc & ~wb_we_i & (sel == SEL_ALT_SET);

  chk_en_clr_write: assert property (   // [RULE3]
    wr_en_clr |=> ((en_q & $past(wr_bits)) == 16'h0000))
    else $error("enable clear write left a channel enabled");

  chk_en_no_rise: assert property (   // [RULE4]
    ((en_q & ~$past(en_q)) & ~$past(sw_en_set)) == 16'h0000)
    else $error("channel enabled without an enable set write");

  chk_en_set_write: assert property (   // [RULE12]
    wr_en_set |=> ((en_q & $past(wr_bits)) == $past(wr_bits)))
    else $error("enable set write did not enable channel");

  chk_en_auto_done: assert property (   // [RULE5]
    (clk_en_i && !wr_en_set && (engine_i.done != 16'h0000))
      |=> ((en_q & $past(engine_i.done)) == 16'h0000))
    else $error("completed channel stayed enabled");

  chk_en_readback: assert property (   // [RULE2]
    rd_en_clr |=> wb_ack_o && (wb_dat_o == {16'h0000, $past(en_q)}))
    else $error("enable clear read did not return enable state");

  chk_alt_readback: assert property (   // [RULE7]
    rd_alt_set |=> wb_ack_o && (wb_dat_o[15:0] == $past(alt_q)))
    else $error("alternate set read did not return select state");

  chk_alt_set_write: assert property (   // [RULE8]
    (acc && wb_we_i && sel == SEL_ALT_SET)
      |=> ((alt_q & $past(wr_bits)) == $past(wr_bits)))
    else $error("alternate set write did not select alternate");

  chk_alt_no_fall: assert property (   // [RULE9]
    ((~alt_q & $past(alt_q)) & ~$past(alt_clr)) == 16'h0000)
    else $error("alternate bit cleared without a clear source");

  chk_alt_engine: assert property (   // [RULE10]
    (clk_en_i && (engine_i.alt_set != 16'h0000))
      |=> ((alt_q & $past(engine_i.alt_set)) == $past(engine_i.alt_set)))
    else $error("engine alternate set not applied");

  chk_reset_zero: assert property (   // [RULE6] [RULE11]
    disable iff (1'b0)
    !rst_n_i |=> (en_q == EN_RST) && (alt_q == ALT_RST))
    else $error("channel state not zero after reset");

  chk_upper_zero: assert property (   // [RULE13]
    wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000))
    else $error("reserved read bits not zero");

  chk_ack_pulse: assert property (   // [RULE1]
    (acc ##1 clk_en_i) |-> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");

  chk_alt_clr_write: assert property (   // [RULE9]
    (acc && wb_we_i && sel == SEL_ALT_CLR && engine_i.alt_set == 16'h0000)
      |=> ((alt_q & $past(wr_bits)) == 16'h0000))
    else $error("alternate clear write left alternate selected");

  chk_alt_engine_clr: assert property (   // [RULE10]
    (clk_en_i && (engine_i.alt_clr != 16'h0000) && (alt_set == 16'h0000))
      |=> ((alt_q & $past(engine_i.alt_clr)) == 16'h0000))
    else $error("engine alternate clear not applied");

  chk_en_clr_no_rise: assert property (   // [RULE4]
    wr_en_clr |=> ((en_q & ~$past(en_q)) == 16'h0000))
    else $error("enable clear write enabled a channel");

  chk_unmapped_read: assert property (   // [RULE13]
    (acc && !wb_we_i && sel == SEL_NONE) |=> (wb_dat_o == RDATA_RST))
    else $error("unmapped read returned nonzero data");

  chk_en_set_read: assert property (   // [RULE12]
    (acc && !wb_we_i && sel == SEL_EN_SET)
      |=> wb_ack_o && (wb_dat_o == {RSVD_READ, $past(en_q)}))
    else $error("enable set read did not return enable state");

  chk_state_frozen: assert property (
    !clk_en_i |=> $stable(en_q) && $stable(alt_q))
    else $error("channel state moved while clock enable low");

  chk_bus_frozen: assert property (
    !clk_en_i |=> $stable(wb_ack_o) && $stable(wb_dat_o))
    else $error("bus answer moved while clock enable low");

  chk_write_rdata_zero: assert property (
    (acc && wb_we_i) |=> (wb_dat_o == RDATA_RST))
    else $error("write left nonzero read data");

  chk_ack_cause: assert property (
    $rose(wb_ack_o) |-> $past(acc))
    else $error("ack raised without an accepted request");

  cov_en_then_done: cover property (
    wr_en_set ##[1:20] (clk_en_i && engine_i.done != 16'h0000));

  cov_alt_pingpong: cover property (
    (clk_en_i && engine_i.alt_set != 16'h0000)
      ##[1:20] (clk_en_i && engine_i.alt_clr != 16'h0000));

  cov_en_clr_read: cover property (
    wr_en_clr ##[2:10] rd_en_clr);

  cov_set_clear_clash: cover property (
    clk_en_i && ((sw_alt_clr & engine_i.alt_set) != 16'h0000));

  cov_frozen_take: cover property (
    (!clk_en_i && wb_cyc_i && wb_stb_i) ##1 acc);

endmodule : dma_chan_ctrl

// ### logic/dma_chan_pkg.sv
//==========================================================================
// Shared constants and types
//==========================================================================
package dma_chan_pkg;

  localparam int NUM_CHAN = 16;

  typedef logic [NUM_CHAN-1:0] chan_vec_t;

  // Register byte addresses
  localparam logic [31:0] ADDR_EN_SET  = 32'h4001_0028;
  localparam logic [31:0] ADDR_EN_CLR  = 32'h4001_002c;
  localparam logic [31:0] ADDR_ALT_SET = 32'h4001_0030;
  localparam logic [31:0] ADDR_ALT_CLR = 32'h4001_0034;

  // Field layout: channel bits in the low half, upper half reserved
  localparam int CHAN_LSB = 0;
  localparam int CHAN_MSB = 15;
  localparam logic [15:0] RSVD_READ = 16'h0000;

  // Reset values
  localparam chan_vec_t EN_RST  = 16'h0000;
  localparam chan_vec_t ALT_RST = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Bus timing: ack follows the request edge by this many cycles
  localparam int ACK_LATENCY = 1;

  typedef enum {
    SEL_NONE,
    SEL_EN_SET,
    SEL_EN_CLR,
    SEL_ALT_SET,
    SEL_ALT_CLR
  } reg_sel_t;

  // Per-channel events from the transfer engine
  typedef struct packed {
    chan_vec_t done;
    chan_vec_t alt_set;
    chan_vec_t alt_clr;
  } engine_evt_t;

  // Live per-channel state handed back to the engine
  typedef struct packed {
    chan_vec_t enable;
    chan_vec_t alt_sel;
  } chan_status_t;

endpackage : dma_chan_pkg

// ### logic/chan_bit_cell.sv
`timescale 1ns/100ps
//==========================================================================
// Vector of set/clear flags, set wins over clear
//==========================================================================
module chan_bit_cell
  import dma_chan_pkg::*;
#(
  parameter int WIDTH = dma_chan_pkg::NUM_CHAN
)
(
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // Controls
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  // State
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (clk_en_i)
    begin
      // A set in the same cycle as a clear is kept
      q_nxt = (q_r & ~clr_i) | set_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule : chan_bit_cell

// ### dv/engine_model.sv
`timescale 1ns/100ps
//==========================================================================
// Transfer engine stand-in: one ping-pong half, then completion
//==========================================================================
module engine_model
(
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  // Commands from the bench
  input  wire logic                      start_i,
  input  wire logic [3:0]                chan_i,
  // Controller side
  input  wire dma_chan_pkg::chan_status_t status_i,
  output dma_chan_pkg::engine_evt_t      engine_o
);
  import dma_chan_pkg::*;

  logic       busy_r;
  logic [3:0] chan_r;

  // Events are single-cycle levels, so clear them every edge
  always_ff @(posedge clock_i)
  begin
    engine_o <= '0;
    busy_r   <= 1'b0;
    if (rst_n_i && start_i && status_i.enable[chan_i])
    begin
      if (status_i.alt_sel[chan_i])
        engine_o.alt_clr[chan_i] <= 1'b1;
      else
        engine_o.alt_set[chan_i] <= 1'b1;
      busy_r <= 1'b1;
      chan_r <= chan_i;
    end
    else if (rst_n_i && busy_r)
      engine_o.done[chan_r] <= 1'b1;
  end
endmodule : engine_model

// ### dv/dma_chan_ctrl_tb.sv
`timescale 1ns/100ps
module dma_chan_ctrl_tb;
  import dma_chan_pkg::*;

  typedef struct packed {
    logic        we;
    logic [31:0] adr;
    logic [31:0] dat;
  } row_t;

  logic         clock_i, rst_n_i, clk_en_i, cyc, stb, we, start, ack;
  logic [31:0]  adr, wdat, rdat, rd;
  logic [3:0]   sel, chan;
  engine_evt_t  engine;
  chan_status_t status_o;
  int           err_total, checks, cycles;

  // Reads expect dat; writes carry it
  row_t rows [16] = '{
    '{1'b0, ADDR_EN_CLR, 32'h0}, '{1'b0, ADDR_ALT_SET, 32'h0},
    '{1'b1, ADDR_EN_SET, 32'hffff_00a5}, '{1'b0, ADDR_EN_SET, 32'h00a5},
    '{1'b1, ADDR_EN_CLR, 32'h0005}, '{1'b0, ADDR_EN_CLR, 32'h00a0},
    '{1'b1, ADDR_EN_CLR, 32'h0}, '{1'b0, ADDR_EN_SET, 32'h00a0},
    '{1'b1, ADDR_ALT_SET, 32'hffff_8001}, '{1'b0, ADDR_ALT_SET, 32'h8001},
    '{1'b1, ADDR_ALT_SET, 32'h0}, '{1'b0, ADDR_ALT_CLR, 32'h8001},
    '{1'b1, ADDR_ALT_CLR, 32'h1}, '{1'b0, ADDR_ALT_SET, 32'h8000},
    '{1'b1, 32'h4001_0038, 32'hffff}, '{1'b0, 32'h4001_0038, 32'h0}};

  dma_chan_ctrl dma_chan_ctrl_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .engine_i(engine), .status_o(status_o));

  engine_model engine_model_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start), .chan_i(chan),
    .status_i(status_o), .engine_o(engine));

  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // Classic single cycle; ack must drop the cycle after it came
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clock_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock_i);
    chk({31'h0, ack}, 32'h0);
  endtask : bus

  task automatic run(input logic [3:0] c);
    int n;
    n = 0;
    @(posedge clock_i);
    start <= 1'b1;
    chan  <= c;
    @(posedge clock_i);
    start <= 1'b0;
    while (status_o.enable[c] !== 1'b0 && n < 20)
    begin
      @(posedge clock_i);
      n++;
    end
    chk({31'h0, status_o.enable[c]}, 32'h0);
  endtask : run

  // Hang guard, far above the 130 or so cycles needed
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    {rst_n_i, cyc, stb, we, start, adr, wdat, chan} = '0;
    clk_en_i = 1'b1;
    sel = 4'hf;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (rows[i])
    begin
      bus(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we)
        chk(rd, rows[i].dat);
    end
    //======================================================================
    // Engine completion and ping-pong swaps
    //======================================================================
    bus(1'b1, ADDR_EN_SET, 32'h8);
    run(4'd3);
    bus(1'b0, ADDR_EN_CLR, 32'h0);
    chk(rd, 32'h00a0);
    bus(1'b0, ADDR_ALT_SET, 32'h0);
    chk(rd, 32'h8008);
    bus(1'b1, ADDR_EN_SET, 32'h8);
    run(4'd3);
    bus(1'b0, ADDR_ALT_SET, 32'h0);
    chk(rd, 32'h8000);
    //======================================================================
    // Reset in mid-run
    //======================================================================
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk(status_o, 32'h0);
    rst_n_i <= 1'b1;
    bus(1'b0, ADDR_EN_CLR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ADDR_ALT_SET, 32'h0);
    chk(rd, 32'h0);
    //======================================================================
    // Clock enable freeze and byte lanes
    //======================================================================
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    fork
      bus(1'b1, ADDR_EN_SET, 32'h0002);
      begin
        repeat (4) @(posedge clock_i);
        chk(status_o, 32'h0);
        chk({31'h0, ack}, 32'h0);
        clk_en_i <= 1'b1;
      end
    join
    bus(1'b0, ADDR_EN_SET, 32'h0);
    chk(rd, 32'h0002);
    sel <= 4'h1;
    bus(1'b1, ADDR_EN_SET, 32'hf0f0);
    sel <= 4'hf;
    bus(1'b0, ADDR_EN_CLR, 32'h0);
    chk(rd, 32'h00f2);
    summarize();
  end
endmodule : dma_chan_ctrl_tb
